// ### verilog/nvram_host_pkg.sv
// shared constants and types for the nonvolatile sram host controller
package nvram_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int SYNC_LAT = 3;
    localparam int CLK_PERIOD_NS = 10;
    // bus timing in ns, turned into whole clock cycles (least times round up)
    localparam int T_ACC_NS = 45;
    localparam int T_WP_NS = 45;
    localparam int T_GAP_NS = 20;
    localparam int T_BUSY_REQ_NS = 50;
    localparam int T_BUSY_START_NS = 500;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_REQ_CYC = (T_BUSY_REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_START_CYC = (T_BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC = ACC_CYC + SYNC_LAT;
    // software command sequence
    localparam int SEQ_LAST = 5;
    localparam logic [ADDR_W-1:0] SEQ_A0 = 17'h04E38;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 17'h0B1C7;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 17'h083E0;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 17'h07C1F;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 17'h0703F;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 17'h08FC0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 17'h04C63;

    typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_HW_STORE} op_type;

    typedef struct packed {
        op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_type;

    typedef struct packed {
        logic ran;
        logic [DATA_W-1:0] data;
    } rsp_type;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
    } pins_type;

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input logic recall);
        logic [ADDR_W-1:0] a;
        a = SEQ_A0;
        case (idx)
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            3'h5: a = recall ? SEQ_RECALL : SEQ_STORE;
            default: a = SEQ_A0;
        endcase
        return a;
    endfunction : seq_addr
endpackage : nvram_host_pkg

// ### verilog/pin_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,           // system clock
    input wire logic rst_n,         // async reset, active low
    input wire logic [W-1:0] d,     // asynchronous pin level
    output logic [W-1:0] q          // filtered, synchronous level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1[i] <= INIT[i];
                    s2[i] <= INIT[i];
                    s3[i] <= INIT[i];
                    q[i] <= INIT[i];
                end else begin
                    s1[i] <= d[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        q[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

// ### verilog/nvram_host.sv
// host controller that drives a nonvolatile-backed sram over its asynchronous pins
`timescale 1ns/1ns
module nvram_host
    import nvram_host_pkg::*;
#(
    parameter int RECALL_WAIT = 20000
) (
    input wire logic CLK,                   // 100 MHz system clock
    input wire logic RSTN,                  // async reset, active low
    input wire req_type REQ,                // request from user logic
    input wire logic REQ_VALID,             // request present
    output logic REQ_READY,                 // request taken when valid and ready
    output logic RSP_VALID,                 // one-cycle completion pulse
    output rsp_type RSP,                    // read data and store-ran flag
    output logic BUSY,                      // busy line seen low
    output pins_type MEM,                   // select, strobes and address pins
    output logic [DATA_W-1:0] DQ_OUT,       // data lines, host drive value
    output logic DQ_OE,                     // host drives data lines
    input wire logic [DATA_W-1:0] DQ_IN,    // data lines level
    output logic STORE_BUSY_N_OUT,          // busy line drive value, always low
    output logic STORE_BUSY_N_OE,           // host pulls busy line low
    input wire logic STORE_BUSY_N_IN        // busy line level
);
    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_WR, S_GAP, S_BUSY_REQ, S_WAIT_START, S_WAIT_END, S_SETTLE
    } state_type;

    state_type state;
    req_type cur;
    logic [CNT_W-1:0] cnt;
    logic [2:0] step;
    logic [DATA_W-1:0] dq_s;
    logic busy_n_s;

    pin_sync #(.W(DATA_W), .INIT('0)) u_dq_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .d(DQ_IN),
        .q(dq_s)
    );

    pin_sync #(.W(1), .INIT(1'b1)) u_busy_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .d(STORE_BUSY_N_IN),
        .q(busy_n_s)
    );

    wire take = REQ_VALID && REQ_READY;
    wire is_seq = (cur.op == OP_SW_STORE) || (cur.op == OP_SW_RECALL);
    wire is_recall = (cur.op == OP_SW_RECALL);
    wire rd_done = (cnt == CNT_W'(RD_CYC - 1));
    wire wr_done = (cnt == CNT_W'(WP_CYC));
    wire gap_done = (cnt == CNT_W'(GAP_CYC - 1));
    wire busy_req_done = (cnt == CNT_W'(BUSY_REQ_CYC - 1));
    wire start_late = (cnt == CNT_W'(BUSY_START_CYC - 1));
    wire recall_done = (cnt == CNT_W'(RECALL_WAIT - 1));
    wire seq_more = is_seq && (step != 3'(SEQ_LAST));
    wire [ADDR_W-1:0] next_seq = seq_addr(step + 3'h1, is_recall);
    wire [ADDR_W-1:0] first_addr = ((REQ.op == OP_SW_STORE) || (REQ.op == OP_SW_RECALL))
                                   ? SEQ_A0 : REQ.addr;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= S_IDLE;
            cur <= '0;
            cnt <= '0;
            step <= '0;
            MEM <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
            DQ_OUT <= '0;
            DQ_OE <= 1'b0;
            STORE_BUSY_N_OUT <= 1'b0;
            STORE_BUSY_N_OE <= 1'b0;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP <= '0;
            BUSY <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            BUSY <= !busy_n_s;
            cnt <= cnt + CNT_W'(1);
            case (state)
                S_IDLE: begin
                    // no new access while the device is storing or recalling
                    REQ_READY <= busy_n_s && !take;
                    cnt <= '0;
                    if (take) begin
                        cur <= REQ;
                        step <= '0;
                        RSP.ran <= 1'b0;
                        MEM.addr <= first_addr;
                        case (REQ.op)
                            OP_WRITE: begin
                                // data and address go out a cycle before the strobe
                                DQ_OUT <= REQ.wdata;
                                DQ_OE <= 1'b1;
                                MEM.oe_n <= 1'b1;
                                MEM.ce_n <= 1'b0;
                                state <= S_WR;
                            end
                            OP_HW_STORE: begin
                                STORE_BUSY_N_OE <= 1'b1;
                                state <= S_BUSY_REQ;
                            end
                            default: begin
                                MEM.ce_n <= 1'b0;
                                MEM.oe_n <= 1'b0;
                                state <= S_RD;
                            end
                        endcase
                    end
                end
                S_RD: begin
                    if (rd_done) begin
                        // sample before any control moves so the data is still held
                        RSP.data <= dq_s;
                        MEM.ce_n <= 1'b1;
                        MEM.oe_n <= 1'b1;
                        cnt <= '0;
                        state <= S_GAP;
                    end
                end
                S_WR: begin
                    if (cnt == '0) begin
                        MEM.we_n <= 1'b0;
                    end
                    if (wr_done) begin
                        MEM.we_n <= 1'b1;
                        MEM.ce_n <= 1'b1;
                        cnt <= '0;
                        state <= S_GAP;
                    end
                end
                S_GAP: begin
                    // address and write data stay put past the rising strobe
                    if (gap_done) begin
                        DQ_OE <= 1'b0;
                        cnt <= '0;
                        if (seq_more) begin
                            // back-to-back chip-select reads, nothing in between
                            step <= step + 3'h1;
                            MEM.addr <= next_seq;
                            MEM.ce_n <= 1'b0;
                            MEM.oe_n <= 1'b0;
                            state <= S_RD;
                        end else if (is_recall) begin
                            state <= S_SETTLE;
                        end else if (is_seq) begin
                            state <= S_WAIT_START;
                        end else begin
                            RSP_VALID <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
                end
                S_BUSY_REQ: begin
                    if (busy_req_done) begin
                        STORE_BUSY_N_OE <= 1'b0;
                        cnt <= '0;
                        state <= S_WAIT_START;
                    end
                end
                S_WAIT_START: begin
                    // device may skip a store with nothing written; give up after a bound
                    if (!busy_n_s) begin
                        RSP.ran <= 1'b1;
                        state <= S_WAIT_END;
                    end else if (start_late) begin
                        RSP_VALID <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_WAIT_END: begin
                    // a stuck-low line holds the controller here on purpose
                    if (busy_n_s) begin
                        RSP_VALID <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_SETTLE: begin
                    if (recall_done) begin
                        RSP_VALID <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_oe_high_write;
        !MEM.we_n |-> MEM.oe_n && DQ_OE;
    endproperty
    a_oe_high_write: assert property (p_oe_high_write) else $error("output drive low in write");

    property p_addr_stable;
        !MEM.we_n ##1 !MEM.we_n |-> $stable(MEM.addr) && $stable(DQ_OUT);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

    property p_we_width;
        $fell(MEM.we_n) |-> (!MEM.we_n && !MEM.ce_n)[*5] ##1 (MEM.we_n && MEM.ce_n && DQ_OE);
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

    property p_no_drive_read;
        !MEM.oe_n |-> !DQ_OE && MEM.we_n;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("host drives during read");

    // the address moves on the edge that lowers the strobes, so it is held from the next one
    property p_read_hold;
        $fell(MEM.oe_n) |-> !MEM.ce_n ##1
            (!MEM.oe_n && !MEM.ce_n && $stable(MEM.addr))[*7] ##1 MEM.oe_n;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read cycle length wrong");

    property p_idle_deselect;
        state == S_IDLE |-> MEM.ce_n && MEM.we_n && !DQ_OE && !STORE_BUSY_N_OE;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect) else $error("bus active in idle");

    property p_ready_gate;
        REQ_READY |-> $past(busy_n_s) && state == S_IDLE;
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("ready while busy");

    property p_req_pulse;
        $rose(STORE_BUSY_N_OE) |-> STORE_BUSY_N_OE[*5] ##1
            (!STORE_BUSY_N_OE && state == S_WAIT_START);
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("busy request pulse wrong");

    property p_seq_start;
        $fell(MEM.ce_n) && is_seq && step == 3'h0 |-> MEM.addr == SEQ_A0;
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("sequence start address");

    property p_seq_end;
        $fell(MEM.ce_n) && is_seq && step == 3'(SEQ_LAST) |->
            MEM.addr == (is_recall ? SEQ_RECALL : SEQ_STORE);
    endproperty
    a_seq_end: assert property (p_seq_end) else $error("sequence end address");

    c_write: cover property ($rose(MEM.we_n) && !MEM.ce_n == 1'b0);
    c_read: cover property (RSP_VALID && cur.op == OP_READ);
    c_sw_store: cover property (RSP_VALID && cur.op == OP_SW_STORE && RSP.ran);
    c_hw_skip: cover property (RSP_VALID && cur.op == OP_HW_STORE && !RSP.ran);
endmodule : nvram_host

// ### tb/nvram_dev_model.sv
// behavioural model of the nonvolatile-backed sram, seen at its pins
`timescale 1ns/1ns
module nvram_dev_model
    import nvram_host_pkg::*;
#(
    parameter int STORE_CYC = 30,
    parameter int RECALL_CYC = 20,
    parameter int DELAY_CYC = 2,
    parameter bit AUTO_EN = 1'b1
) (
    input wire logic clk, // sampling clock
    input wire pins_type pins, // select, strobes and address
    input wire logic [DATA_W-1:0] dq_in, // data line level
    output logic [DATA_W-1:0] dq_out, // read data
    output logic dq_oe, // device drives data lines
    input wire logic store_busy_n_in, // busy line level
    output logic store_busy_pull, // device pulls busy line low
    input wire logic pwr_fail, // supply below switchover
    output int stores, // stores carried out
    output int recalls // recalls carried out
);
    logic [DATA_W-1:0] sram [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] nv [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] seq_tab [0:4];
    pins_type prev;
    logic [DATA_W-1:0] wbuf;
    logic written, is_store, hw_req, pf_prev, pw, pr;
    int busy, idx, dly;
    wire logic idle = (busy == 0);
    wire logic rd = !pins.ce_n && !pins.oe_n && pins.we_n && store_busy_n_in && idle;
    wire logic wr = !pins.ce_n && !pins.we_n && store_busy_n_in && idle;
    wire logic seq_rd = !pins.ce_n && pins.we_n && idle;

    initial begin
        seq_tab = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
        {written, is_store, hw_req, pf_prev, pw, pr, store_busy_pull, dq_oe} = '0;
        {busy, idx, dly, stores, recalls} = '0;
        dq_out = '0;
        prev = '{1'b1, 1'b1, 1'b1, '0};
    end

    // the clear before a recall is hidden, since every cell is loaded afterwards
    task automatic begin_op(input logic st);
        is_store = st;
        busy = st ? STORE_CYC : RECALL_CYC;
        if (st) begin
            nv = sram;
            stores++;
        end else begin
            sram = nv;
            recalls++;
        end
    endtask : begin_op

    always @(posedge clk) begin
        if (busy > 0) begin
            busy--;
            if (busy == 0) written = 1'b0;
        end
        if (wr) wbuf = dq_in;
        if (pw && !wr) begin
            sram[prev.addr] = wbuf;
            written = 1'b1;
            idx = 0;
        end
        if (pr && !seq_rd) begin
            if (idx < 5 && prev.addr == seq_tab[idx]) begin
                idx++;
            end else begin
                if (idx == 5 && prev.addr == SEQ_STORE) begin_op(1'b1);
                else if (idx == 5 && prev.addr == SEQ_RECALL) begin_op(1'b0);
                idx = (prev.addr == SEQ_A0) ? 1 : 0;
            end
        end
        if (!store_busy_n_in && !store_busy_pull && idle && !hw_req) begin
            hw_req = 1'b1;
            dly = DELAY_CYC;
        end else if (hw_req) begin
            if (dly > 0) dly--;
            else begin
                hw_req = 1'b0;
                if (written && idle) begin_op(1'b1);
            end
        end
        // supply loss: the backup cap is cut off the supply and powers this store
        if (pwr_fail && !pf_prev && AUTO_EN && written && idle) begin_op(1'b1);
        pf_prev = pwr_fail;
        pw = wr;
        pr = seq_rd;
        prev = pins;
        dq_out <= sram[pins.addr];
        dq_oe <= rd;
        store_busy_pull <= (busy != 0) && is_store;
    end
endmodule : nvram_dev_model

// ### tb/nvram_host_tb_top.sv
// self-checking bench: host controller against the behavioural device model
`timescale 1ns/1ns
module nvram_host_tb_top
    import nvram_host_pkg::*;
;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    req_type REQ = '0;
    logic REQ_VALID = 1'b0;
    logic pwr_fail = 1'b0;
    logic REQ_READY, RSP_VALID, BUSY, DQ_OE, dev_oe, dev_pull;
    logic STORE_BUSY_N_OUT, STORE_BUSY_N_OE, STORE_BUSY_N_IN;
    rsp_type RSP;
    pins_type MEM, prev_mem;
    logic [DATA_W-1:0] DQ_OUT, dev_dq, dq_line;
    logic [DATA_W-1:0] dq_last = '0;
    int stores, recalls;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 CLK = ~CLK;
    assign STORE_BUSY_N_IN = ~((STORE_BUSY_N_OE & ~STORE_BUSY_N_OUT) | dev_pull);
    // undriven data lines show the inverse of the last driven value so stale values cannot pass for read data
    assign dq_line = DQ_OE ? DQ_OUT : (dev_oe ? dev_dq : ~dq_last);
    always @(posedge CLK) begin
        if (DQ_OE || dev_oe) dq_last <= dq_line;
    end

    nvram_host #(.RECALL_WAIT(50)) i_dut (.CLK(CLK), .RSTN(RSTN), .REQ(REQ),
        .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP),
        .BUSY(BUSY), .MEM(MEM), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(dq_line),
        .STORE_BUSY_N_OUT(STORE_BUSY_N_OUT), .STORE_BUSY_N_OE(STORE_BUSY_N_OE),
        .STORE_BUSY_N_IN(STORE_BUSY_N_IN));
    nvram_dev_model i_dev (.clk(CLK), .pins(MEM), .dq_in(dq_line), .dq_out(dev_dq),
        .dq_oe(dev_oe), .store_busy_n_in(STORE_BUSY_N_IN), .store_busy_pull(dev_pull),
        .pwr_fail(pwr_fail),
        .stores(stores), .recalls(recalls));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_vec

    task automatic chk_cnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    always @(posedge CLK) begin
        if (RSTN && !MEM.ce_n && !MEM.we_n) begin
            chk_vec("oe_n in write", 32'h1, {31'h0, MEM.oe_n});
            if (!prev_mem.ce_n && !prev_mem.we_n)
                chk_vec("write address", {15'h0, prev_mem.addr}, {15'h0, MEM.addr});
        end
        if (DQ_OE && dev_oe) chk_vec("data line owners", 32'h1, 32'h2);
        prev_mem <= MEM;
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            $display("[FAIL] run time expected below 30000 cycles seen 30000");
            conclude();
        end
    end

    task automatic do_op(input op_type op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        REQ <= '{op: op, addr: a, wdata: d};
        REQ_VALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 200);
        REQ_VALID <= 1'b0;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (RSP_VALID !== 1'b1 && n < 400);
        if (n >= 400) chk_vec("response", 32'h1, 32'h0);
    endtask : do_op

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        do_op(OP_READ, a, '0);
        chk_vec("read data", {24'h0, e}, {24'h0, RSP.data});
    endtask : rd_chk

    task automatic t_sw_clean();
        int s;
        s = stores;
        do_op(OP_SW_STORE, '0, '0);
        chk_vec("store ran", 32'h1, {31'h0, RSP.ran});
        chk_cnt("stores", s + 1, stores);
        $display("test sw_clean done");
    endtask : t_sw_clean

    task automatic t_hw();
        int s;
        s = stores;
        do_op(OP_HW_STORE, '0, '0);
        chk_cnt("stores", s, stores);
        do_op(OP_WRITE, 17'h00040, 8'h77);
        do_op(OP_HW_STORE, '0, '0);
        chk_cnt("stores", s + 1, stores);
        chk_vec("busy drive level", 32'h0, {31'h0, STORE_BUSY_N_OUT});
        $display("test hw_store done");
    endtask : t_hw

    task automatic t_rw();
        logic [ADDR_W-1:0] at [0:2];
        logic [DATA_W-1:0] dt [0:2];
        at = '{17'h00000, 17'h1FFFF, 17'h0B1C7};
        dt = '{8'hA5, 8'h5A, 8'hFF};
        for (int i = 0; i < 3; i++) do_op(OP_WRITE, at[i], dt[i]);
        for (int i = 0; i < 3; i++) rd_chk(at[i], dt[i]);
        $display("test read_write done");
    endtask : t_rw

    task automatic t_recall();
        int r;
        do_op(OP_WRITE, 17'h00100, 8'h3C);
        do_op(OP_SW_STORE, '0, '0);
        do_op(OP_WRITE, 17'h00100, 8'hC3);
        rd_chk(17'h00100, 8'hC3);
        r = recalls;
        do_op(OP_SW_RECALL, '0, '0);
        chk_cnt("recalls", r + 1, recalls);
        rd_chk(17'h00100, 8'h3C);
        $display("test recall done");
    endtask : t_recall

    task automatic t_abort();
        int s;
        logic [ADDR_W-1:0] seq [0:4];
        seq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
        s = stores;
        for (int i = 0; i < 5; i++) do_op(OP_READ, seq[i], '0);
        do_op(OP_WRITE, 17'h00200, 8'h11);
        do_op(OP_READ, SEQ_STORE, '0);
        chk_cnt("stores", s, stores);
        $display("test abort done");
    endtask : t_abort

    task automatic t_power();
        int s;
        int n;
        s = stores;
        n = 0;
        @(posedge CLK);
        pwr_fail <= 1'b1;
        while (BUSY !== 1'b1 && n < 20) begin
            @(posedge CLK);
            n++;
        end
        chk_vec("busy on supply loss", 32'h1, {31'h0, BUSY});
        chk_vec("ready while busy", 32'h0, {31'h0, REQ_READY});
        chk_cnt("stores", s + 1, stores);
        while (BUSY !== 1'b0 && n < 100) begin
            @(posedge CLK);
            n++;
        end
        chk_vec("busy after store", 32'h0, {31'h0, BUSY});
        pwr_fail <= 1'b0;
        $display("test power_loss done");
    endtask : t_power

    initial begin
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        t_sw_clean();
        t_hw();
        t_rw();
        t_recall();
        t_abort();
        t_power();
        conclude();
    end
endmodule : nvram_host_tb_top
